// ### pkg/pcd_map.svh
// Purpose: Timing counts and level-code constants for the dimming control
// Assumes: Clock clk_sys at 10 MHz (100 ns period)
// Notes: Times kept in their own unit, cycle counts derived from them
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define PCD_CLK_HZ 10000000

// ----------------------------------------------------------------------
// Control line timing
// ----------------------------------------------------------------------
// Least high or low pulse width, in nanoseconds (rounded up)
`define PCD_T_PULSE_NS 400
`define PCD_PULSE_CYC \
    ((`PCD_T_PULSE_NS * (`PCD_CLK_HZ / 1000000) + 999) / 1000)
// Longest low gap while stepping, in microseconds
`define PCD_T_GAP_US 1000
`define PCD_GAP_CYC (`PCD_T_GAP_US * (`PCD_CLK_HZ / 1000000))
// Shutdown low time, in microseconds
`define PCD_T_OFF_US 5500
`define PCD_OFF_CYC (`PCD_T_OFF_US * (`PCD_CLK_HZ / 1000000))

// ----------------------------------------------------------------------
// Level code
// ----------------------------------------------------------------------
`define PCD_LEVEL_PRESET 5'h00
`define PCD_DUTY_W 8

`endif

// ### pkg/pcd_pkg.sv
// Purpose: Types for the pulse-count dimming control
// Assumes: Constants come from pcd_map.svh
// Notes: Level code held as value minus one (0 means code 1)
package pcd_pkg;

    // Operating state of the enable logic
    typedef enum logic [1:0] {
        PCD_SHUTDOWN = 2'b00,
        PCD_HIGH = 2'b01,
        PCD_LOW = 2'b10
    } pcd_state_t;

    // Drive bundle handed to the analogue side
    typedef struct packed {
        logic active;
        logic [4:0] level;
        logic [7:0] dim_ref;
    } pcd_drive_t;

endpackage

// ### verilog/pcd_ctrl.sv
// Purpose: Control-line pulse decoder, shutdown detect and PWM dimming
// Assumes: ctrl_line and pwm_in are asynchronous pins; one 10 MHz clock
// Notes: dim_ref is the filtered, duty-scaled reference code
`include "pcd_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pcd_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pins
    input wire logic ctrl_line,
    input wire logic pwm_in,
    input wire logic pwm_in_driven,
    // Drive to the analogue side
    output logic device_active,
    output logic led_channel_sink_en,
    output logic [4:0] level_code,
    output logic [7:0] selected_reference_level,
    output logic [7:0] dim_ref
);

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam int PULSE_CYC = `PCD_PULSE_CYC;
    localparam int OFF_CYC = `PCD_OFF_CYC;
    localparam logic [15:0] PULSE_Q = 16'(PULSE_CYC);
    localparam logic [15:0] OFF_Q = 16'(OFF_CYC);

    // ------------------------------------------------------------------
    // Reference for each level code, 8-bit scale where 255 is 25 mA
    // ------------------------------------------------------------------
    // A table rather than a ramp: the current steps are not even, and a
    // formula drifts far off in the lower half of the range
    function automatic logic [7:0] ref_of(input logic [4:0] code);
        logic [7:0] r;
        r = 8'h00;
        case (code)
            5'h00: r = 8'hFF; // Preset, full current
            5'h01: r = 8'hF5;
            5'h02: r = 8'hEB;
            5'h03: r = 8'hE0;
            5'h04: r = 8'hD6;
            5'h05: r = 8'hCC;
            5'h06: r = 8'hC3;
            5'h07: r = 8'hB9;
            5'h08: r = 8'hAD;
            5'h09: r = 8'hA3;
            5'h0A: r = 8'h98;
            5'h0B: r = 8'h8E;
            5'h0C: r = 8'h83;
            5'h0D: r = 8'h78;
            5'h0E: r = 8'h6D;
            5'h0F: r = 8'h63;
            5'h10: r = 8'h58;
            5'h11: r = 8'h52;
            5'h12: r = 8'h4D;
            5'h13: r = 8'h46;
            5'h14: r = 8'h41;
            5'h15: r = 8'h3B;
            5'h16: r = 8'h36;
            5'h17: r = 8'h30;
            5'h18: r = 8'h2B;
            5'h19: r = 8'h25;
            5'h1A: r = 8'h20;
            5'h1B: r = 8'h1B;
            5'h1C: r = 8'h15;
            5'h1D: r = 8'h10;
            5'h1E: r = 8'h0B;
            5'h1F: r = 8'h06; // Last code, lowest current
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers (two flops each)
    // ------------------------------------------------------------------
    logic ctrl_s1, ctrl_s2; // Control line sync pair
    logic pwm_s1, pwm_s2; // PWM pin sync pair
    logic drv_s1, drv_s2; // PWM drive-present sync pair
    logic pwm_lvl; // PWM level after the pull-up

    // First flop feeds only the second
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_s1 <= 1'b0;
            ctrl_s2 <= 1'b0;
            pwm_s1 <= 1'b1;
            pwm_s2 <= 1'b1;
            drv_s1 <= 1'b0;
            drv_s2 <= 1'b0;
        end else begin
            ctrl_s1 <= ctrl_line;
            ctrl_s2 <= ctrl_s1;
            pwm_s1 <= pwm_in;
            pwm_s2 <= pwm_s1;
            drv_s1 <= pwm_in_driven;
            drv_s2 <= drv_s1;
        end
    end

    // Floating PWM reads high as the pull-up would make it; the mux sits
    // behind both sync pairs so no logic ever reads a raw pin
    assign pwm_lvl = drv_s2 ? pwm_s2 : 1'b1;

    // ------------------------------------------------------------------
    // Width counters
    // ------------------------------------------------------------------
    logic [15:0] high_cnt;
    logic [15:0] low_cnt;
    logic high_qual;

    // High counter saturates; qualifies a pulse once it hits 0.4 us
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            high_cnt <= 16'h0000;
        end else if (!ctrl_s2) begin
            high_cnt <= 16'h0000;
        end else if (high_cnt != PULSE_Q) begin
            high_cnt <= high_cnt + 16'h0001;
        end
    end

    // Qualifying edge: the cycle the high time reaches its minimum
    assign high_qual = ctrl_s2 && (high_cnt == PULSE_Q - 16'h0001);

    // Long-low counter saturates at the shutdown time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            low_cnt <= 16'h0000;
        end else if (ctrl_s2) begin
            low_cnt <= 16'h0000;
        end else if (low_cnt != OFF_Q) begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Enable state machine and level code
    // ------------------------------------------------------------------
    pcd_pkg::pcd_state_t state;
    logic [4:0] level;

    // Gaps shorter than the shutdown time keep the device on, so a
    // 1 ms stepping gap is always safe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= pcd_pkg::PCD_SHUTDOWN;
        end else begin
            case (state)
                pcd_pkg::PCD_SHUTDOWN: begin
                    if (high_qual) begin
                        state <= pcd_pkg::PCD_HIGH;
                    end
                end
                pcd_pkg::PCD_HIGH: begin
                    if (!ctrl_s2) begin
                        state <= pcd_pkg::PCD_LOW;
                    end
                end
                pcd_pkg::PCD_LOW: begin
                    if (low_cnt == OFF_Q - 16'h0001) begin
                        state <= pcd_pkg::PCD_SHUTDOWN;
                    end else if (high_qual) begin
                        state <= pcd_pkg::PCD_HIGH;
                    end
                end
                default: begin
                    state <= pcd_pkg::PCD_SHUTDOWN;
                end
            endcase
        end
    end

    // Level code: preset on wake, step on each qualified pulse after
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            level <= `PCD_LEVEL_PRESET;
        end else if (high_qual) begin
            if (state == pcd_pkg::PCD_SHUTDOWN) begin
                level <= `PCD_LEVEL_PRESET;
            end else if (state == pcd_pkg::PCD_LOW) begin
                // Five-bit add wraps code 32 back to code 1
                level <= level + 5'h01;
            end
        end
        // Otherwise unchanged while the line stays high
    end

    // ------------------------------------------------------------------
    // PWM chopping and low-pass filter
    // ------------------------------------------------------------------
    logic [7:0] chopped;
    logic [15:0] filt;

    // Chop the reference at the PWM duty (high passes full reference)
    assign chopped = pwm_lvl ? ref_of(level) : 8'h00;

    // First-order filter: filt += x - filt / 256; top byte gives DC equal to
    // duty times reference. Slow settle is the price of low ripple.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            filt <= 16'h0000;
        end else if (state == pcd_pkg::PCD_SHUTDOWN) begin
            filt <= 16'h0000;
        end else begin
            filt <= filt - 16'(filt >> 8) + 16'(chopped);
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            device_active <= 1'b0;
            led_channel_sink_en <= 1'b0;
            level_code <= 5'h00;
            selected_reference_level <= 8'h00;
            dim_ref <= 8'h00;
        end else begin
            device_active <= (state != pcd_pkg::PCD_SHUTDOWN);
            led_channel_sink_en <= (state != pcd_pkg::PCD_SHUTDOWN);
            level_code <= level;
            selected_reference_level <= ref_of(level);
            // Constant-high PWM settles to the full reference
            dim_ref <= (state == pcd_pkg::PCD_SHUTDOWN) ? 8'h00 :
                filt[15:8];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Last cycle of a shutdown-length low
    sequence s_long_low;
        state == pcd_pkg::PCD_LOW && low_cnt == OFF_Q - 16'h0001;
    endsequence

    // First qualified high while shut down
    sequence s_wake;
        state == pcd_pkg::PCD_SHUTDOWN && high_qual;
    endsequence

    shutdown_entry_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_long_low |=> state == pcd_pkg::PCD_SHUTDOWN ##1 !device_active)
        else $error("long low did not shut down");

    sinks_off_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state == pcd_pkg::PCD_SHUTDOWN |=>
        !led_channel_sink_en && dim_ref == 8'h00)
        else $error("sinks on in shutdown");

    wake_preset_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_wake |=> level == 5'h00 ##1 device_active)
        else $error("wake did not preset level");

    wake_state_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_wake |=> state == pcd_pkg::PCD_HIGH)
        else $error("qualified high did not wake");

    step_wrap_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state == pcd_pkg::PCD_LOW && high_qual |=>
        level == 5'($past(level) + 5'h01))
        else $error("level did not step");

    hold_high_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state == pcd_pkg::PCD_HIGH && ctrl_s2 |=> $stable(level))
        else $error("level changed while high");

    short_gap_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state == pcd_pkg::PCD_LOW && low_cnt < 16'(`PCD_GAP_CYC) |=>
        state != pcd_pkg::PCD_SHUTDOWN)
        else $error("short gap shut down");

    chop_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !pwm_lvl |-> chopped == 8'h00)
        else $error("chop passed reference while pwm low");

    // A qualified pulse has seen the line high for four samples
    min_width_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        high_qual |-> $past(ctrl_s2, 3) && $past(ctrl_s2, 2) &&
        $past(ctrl_s2))
        else $error("pulse qualified too early");

    ref_table_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        level == 5'h00 |=> selected_reference_level == 8'hFF)
        else $error("preset reference wrong");

endmodule

`default_nettype wire

// ### verification/pcd_host.sv
// Purpose: Host pin model for the control line and the PWM pin
// Assumes: 10 MHz clk_sys; pins change just after the rising edge
// Notes: Short PWM period so the bench can average the filter quickly
`timescale 1ns/1ps
`default_nettype none
module pcd_host (
    // Clock
    input wire logic clk_sys,
    // Pins
    output logic ctrl_line,
    output logic pwm_in,
    output logic pwm_in_driven
);
    int pwm_per = 200; // 50 kHz period in cycles
    int pwm_hi = 200; // High cycles in a period
    int pwm_cnt = 0; // Position in the period
    initial begin
        ctrl_line = 1'b0;
        pwm_in = 1'b1;
        pwm_in_driven = 1'b1;
    end
    // PWM source; a floating pin shows the level opposite its pull-up
    always @(posedge clk_sys) begin
        pwm_cnt <= (pwm_cnt + 1) % pwm_per;
        pwm_in <= pwm_in_driven ? (pwm_cnt < pwm_hi) : 1'b0;
    end
    // Hold the line at one level for n cycles
    task automatic hold(input logic v, input int n);
        ctrl_line <= v;
        repeat (n) @(posedge clk_sys);
    endtask
    // Stepping pulses with gaps far below the long-low limit
    task automatic pulses(input int n);
        repeat (n) begin
            hold(1'b0, 10);
            hold(1'b1, 10);
        end
    endtask
    // Too-short high, then one proper pulse
    task automatic glitch();
        hold(1'b0, 10);
        hold(1'b1, 2);
        hold(1'b0, 10);
        hold(1'b1, 10);
    endtask
    // Duty and drive of the PWM pin
    task automatic set_pwm(input int hi, input logic drv);
        pwm_hi <= hi;
        pwm_in_driven <= drv;
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Purpose: Self-checking bench for the pulse-count dimming control
// Assumes: pcd_host drives the pins; 10 MHz clock
// Notes: Shutdown hold is the long part of the run
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0; // 10 MHz clock
    logic rst_n = 1'b0; // Synchronous reset, active low
    logic ctrl_line, pwm_in, pwm_in_driven; // Pins from the host
    logic device_active, led_channel_sink_en; // Enable outputs
    logic [4:0] level_code; // Level code minus one
    logic [7:0] selected_reference_level, dim_ref; // References
    int n_mismatch = 0; // Mismatches seen
    int samples_checked = 0; // Comparisons made
    int cycles = 0; // Cycle count for the timeout
    always #50 clk_sys = ~clk_sys;
    pcd_host host (.clk_sys(clk_sys), .ctrl_line(ctrl_line),
        .pwm_in(pwm_in), .pwm_in_driven(pwm_in_driven));
    pcd_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .ctrl_line(ctrl_line), .pwm_in(pwm_in),
        .pwm_in_driven(pwm_in_driven), .device_active(device_active),
        .led_channel_sink_en(led_channel_sink_en),
        .level_code(level_code),
        .selected_reference_level(selected_reference_level),
        .dim_ref(dim_ref));
    // Verdict and end of run
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Reference expected for a level code: nominal current scaled so
    // that 25 mA reads 255, rounded to the nearest step
    function automatic logic [7:0] exp_ref(input int k);
        int ma10 [32] = '{250, 240, 230, 220, 210, 200, 191, 181, 170,
            160, 149, 139, 128, 118, 107, 97, 86, 80, 75, 69, 64, 58,
            53, 47, 42, 36, 31, 26, 21, 16, 11, 6}; // Tenths of a mA
        return 8'((ma10[k] * 102 + 50) / 100);
    endfunction
    // Active device at a given level
    task automatic check_state(input int k);
        @(negedge clk_sys);
        check(device_active, 1);
        check(led_channel_sink_en, 1);
        check(level_code, k);
        check(selected_reference_level, exp_ref(k));
        @(posedge clk_sys);
    endtask
    // Shut down state
    task automatic check_off();
        @(negedge clk_sys);
        check({device_active, led_channel_sink_en, dim_ref}, 0);
        @(posedge clk_sys);
    endtask
    // Wake, preset, hold while high
    task automatic t_wake();
        host.hold(1'b1, 20);
        check_state(0);
        host.hold(1'b1, 100);
        check_state(0);
    endtask
    // Steps, short high ignored, wrap and modulo count
    task automatic t_step();
        host.glitch();
        host.pulses(6);
        check_state(7);
        host.pulses(24);
        check_state(31);
        host.pulses(13);
        check_state(12);
        host.hold(1'b0, 10000);
        host.hold(1'b1, 20);
        check_state(13);
    endtask
    // PWM full, floating and quarter duty
    task automatic t_dim();
        int sum;
        int d;
        sum = 0;
        host.set_pwm(200, 1'b1);
        host.hold(1'b1, 4000);
        @(negedge clk_sys);
        check(dim_ref, exp_ref(13));
        @(posedge clk_sys);
        host.set_pwm(200, 1'b0);
        host.hold(1'b1, 4000);
        @(negedge clk_sys);
        check(dim_ref, exp_ref(13));
        @(posedge clk_sys);
        host.set_pwm(50, 1'b1);
        host.hold(1'b1, 4000);
        repeat (2000) begin
            @(negedge clk_sys);
            sum += dim_ref;
        end
        @(posedge clk_sys);
        d = sum / 2000 - exp_ref(13) / 4;
        check(d >= -8 && d <= 8, 1);
    endtask
    // Long low: still on just before, off after, fresh preset
    task automatic t_off();
        host.set_pwm(200, 1'b1);
        host.hold(1'b0, 54000);
        @(negedge clk_sys);
        check(device_active, 1);
        @(posedge clk_sys);
        host.hold(1'b0, 2000);
        check_off();
        host.hold(1'b1, 20);
        check_state(0);
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 95000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check_off();
        t_wake();
        t_step();
        t_dim();
        t_off();
        end_of_test();
    end
endmodule
`default_nettype wire
